/* uh_host_attach.sv */
// usb host attach detection, link status and endpoint buffer data port
// assumes a wishbone classic master, async d+/d- pins, a packet engine on clk
//
// Added by the designer: the register addresses and the Wishbone slave port.
`include "uh_defs.svh"
`default_nettype none
module uh_host_attach (
    input wire logic clk, // 40 mhz base clock
    input wire logic srst, // synchronous reset, active high
    input wire uh_pkg::uh_wb_req_s wb_req, // wishbone request
    output var uh_pkg::uh_wb_rsp_s wb_rsp, // wishbone ack and read data
    input wire logic dp_in, // d+ line level, async
    input wire logic dm_in, // d- line level, async
    input wire uh_pkg::uh_link_ev_s link_ev, // packet engine events
    output var uh_pkg::uh_hs_s hs_out, // handshake to send
    output logic attach_irq, // attach interrupt, level
    output logic usb_enable, // block enable
    output logic host_role, // host role selected
    output logic speed_clock_choice, // clock select for speed
    output logic hub_ok // hub tier allowed
);
    import uh_pkg::*;

    uh_state_s st_reg;
    uh_state_s st_next;

    logic present;
    logic acc;
    logic wr;
    logic [31:0] rdat;
    logic [15:0] word;
    logic [15:0] wdat;

    // register addressing and read mux
    always_comb begin
        present = st_reg.pin_s2[0] | st_reg.pin_s2[1];
        acc = wb_req.cyc & wb_req.stb & ~st_reg.rsp.ack;
        wr = acc & wb_req.we;
        word = st_reg.mem[st_reg.widx];
        rdat = 32'h0000_0000;
        unique case (wb_req.adr)
            `UH_OFS_ENABLE: rdat[`UH_B_USB_BLOCK_ENABLE] = st_reg.usb_en;
            `UH_OFS_HCTRL: begin
                rdat[`UH_B_HOST] = st_reg.host_role;
                rdat[`UH_B_ATTACH_IRQ_ENABLE] = st_reg.cnn_ire;
            end
            `UH_OFS_HOST_LINK_STATE_REG: begin
                rdat[`UH_B_ATTACH] = st_reg.attached;
                rdat[`UH_B_SPEED] = st_reg.speed_fs;
                rdat[`UH_B_SPEED_CLOCK_CHOICE] = st_reg.clk_sel;
                rdat[`UH_B_HUBOK] = st_reg.hub_ok;
            end
            `UH_OFS_HREQ: begin
                rdat[`UH_B_CNNREQ] = st_reg.cnn_req;
                rdat[`UH_B_DISREQ] = st_reg.dis_req;
            end
            `UH_OFS_FUNC: begin
                rdat[`UH_B_FRST] = st_reg.func_rst;
                rdat[`UH_B_BFINI] = st_reg.bfini;
            end
            `UH_OFS_EPDATA: begin
                // lanes not selected read as zero
                if (wb_req.sel == `UH_SEL_HALF) begin
                    rdat[15:0] = word;
                end else if (wb_req.sel == `UH_SEL_LOW) begin
                    rdat[7:0] = word[7:0];
                end else if (wb_req.sel == `UH_SEL_HIGH) begin
                    rdat[15:8] = word[15:8];
                end
            end
            `UH_OFS_HERR: begin
                rdat[`UH_B_CRC] = st_reg.crc_e;
                rdat[`UH_B_TOG] = st_reg.tog_e;
                rdat[`UH_B_TMO] = st_reg.tmo_e;
                rdat[`UH_F_HS_HI:`UH_F_HS_LO] = st_reg.hs_last;
            end
            default: rdat = 32'h0000_0000;
        endcase
    end

    // next state: bus writes first, hardware sets afterwards so sets win
    always_comb begin
        st_next = st_reg;
        wdat = 16'h0000;
        st_next.pin_s1 = {dm_in, dp_in};
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.rsp.ack = acc;
        st_next.rsp.dat = acc ? rdat : 32'h0000_0000;
        st_next.hs.send = 1'b0;

        if (wr) begin
            unique case (wb_req.adr)
                `UH_OFS_ENABLE: st_next.usb_en = wb_req.dat[`UH_B_USB_BLOCK_ENABLE];
                `UH_OFS_HCTRL: begin
                    st_next.host_role = wb_req.dat[`UH_B_HOST];
                    st_next.cnn_ire = wb_req.dat[`UH_B_ATTACH_IRQ_ENABLE];
                end
                `UH_OFS_HOST_LINK_STATE_REG: st_next.clk_sel = wb_req.dat[`UH_B_SPEED_CLOCK_CHOICE];
                `UH_OFS_HREQ: begin
                    // writing one is ignored, zero clears
                    if (!wb_req.dat[`UH_B_CNNREQ]) begin
                        st_next.cnn_req = 1'b0;
                    end
                    if (!wb_req.dat[`UH_B_DISREQ]) begin
                        st_next.dis_req = 1'b0;
                    end
                end
                `UH_OFS_FUNC: begin
                    st_next.func_rst = wb_req.dat[`UH_B_FRST];
                    // function reset forces buffer init on as well
                    st_next.bfini = wb_req.dat[`UH_B_BFINI] | wb_req.dat[`UH_B_FRST];
                end
                `UH_OFS_HERR: begin
                    if (!wb_req.dat[`UH_B_CRC]) begin
                        st_next.crc_e = 1'b0;
                    end
                    if (!wb_req.dat[`UH_B_TOG]) begin
                        st_next.tog_e = 1'b0;
                    end
                    if (!wb_req.dat[`UH_B_TMO]) begin
                        st_next.tmo_e = 1'b0;
                    end
                end
                default: st_next.usb_en = st_reg.usb_en;
            endcase
        end

        // data port: half-word and high-byte accesses advance the buffer, so each must be taken once
        if (acc && wb_req.adr == `UH_OFS_EPDATA) begin
            wdat = st_reg.mem[st_reg.widx];
            if (wb_req.sel == `UH_SEL_HALF) begin
                wdat = wb_req.dat[15:0];
                st_next.widx = st_reg.widx + 1'b1;
                st_next.phase = 1'b0;
            end else if (wb_req.sel == `UH_SEL_LOW) begin
                wdat[7:0] = wb_req.dat[7:0];
                st_next.phase = 1'b1;
            end else if (wb_req.sel == `UH_SEL_HIGH) begin
                wdat[15:8] = wb_req.dat[15:8];
                st_next.widx = st_reg.widx + 1'b1;
                st_next.phase = 1'b0;
            end
            if (wb_req.we) begin
                st_next.mem[st_reg.widx] = wdat;
            end
        end

        // buffer init holds the port at word zero, low byte
        if (st_next.bfini) begin
            st_next.widx = '0;
            st_next.phase = 1'b0;
        end

        // attach and detach detection, independent of the host role
        unique case (st_reg.det)
            UH_DET_IDLE: begin
                st_next.cnt = '0;
                if (present) begin
                    st_next.det = UH_DET_WAIT;
                end
            end
            UH_DET_WAIT: begin
                st_next.cnt = st_reg.cnt + 1'b1;
                if (!present) begin
                    st_next.det = UH_DET_IDLE;
                end else if (st_reg.cnt == `UH_CNT_W'(`UH_ATT_CYC - 1)) begin
                    st_next.det = UH_DET_ON;
                    st_next.attached = 1'b1;
                    st_next.speed_fs = st_reg.pin_s2[0];
                    st_next.cnn_req = 1'b1;
                end
            end
            UH_DET_ON: begin
                st_next.cnt = '0;
                if (!present) begin
                    st_next.det = UH_DET_OFF;
                end
            end
            UH_DET_OFF: begin
                // both lines low long enough means the device went away
                st_next.cnt = st_reg.cnt + 1'b1;
                if (present) begin
                    st_next.det = UH_DET_ON;
                end else if (st_reg.cnt == `UH_CNT_W'(`UH_ATT_CYC - 1)) begin
                    st_next.det = UH_DET_IDLE;
                    st_next.attached = 1'b0;
                    st_next.dis_req = 1'b1;
                end
            end
        endcase

        // handshake after in data: only ack, the host never stalls
        if (link_ev.rx_data_ok && st_reg.host_role) begin
            st_next.hs.send = 1'b1;
            st_next.hs.pid = `UH_PID_ACK;
        end
        // after out data the device handshake is captured and classified
        if (link_ev.tx_data_done) begin
            st_next.wait_hs = 1'b1;
            st_next.hs_last = `UH_PID_NONE;
        end
        if (st_reg.wait_hs && link_ev.hs_valid) begin
            st_next.wait_hs = 1'b0;
            st_next.hs_last = link_ev.hs_pid;
        end
        if (link_ev.timeout) begin
            st_next.wait_hs = 1'b0;
        end

        // error flags are sticky; a set beats a clear in the same cycle
        st_next.crc_e = st_next.crc_e | link_ev.crc_err;
        st_next.tog_e = st_next.tog_e | link_ev.toggle_err;
        st_next.tmo_e = st_next.tmo_e | link_ev.timeout;

        st_next.irq = st_next.cnn_req & st_next.cnn_ire;
        st_next.hub_ok = st_next.attached & st_next.speed_fs;
    end

    // single state register
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.bfini <= 1'b1;
            st_reg.det <= UH_DET_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign wb_rsp = st_reg.rsp;
    assign hs_out = st_reg.hs;
    assign attach_irq = st_reg.irq;
    assign usb_enable = st_reg.usb_en;
    assign host_role = st_reg.host_role;
    assign speed_clock_choice = st_reg.clk_sel;
    assign hub_ok = st_reg.hub_ok;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    attach_after_wait_a: assert property (
        st_reg.det == UH_DET_WAIT && present && st_reg.cnt == `UH_CNT_W'(`UH_ATT_CYC - 1)
        |=> st_reg.attached && st_reg.cnn_req)
        else $error("attach not flagged after settle time");
    attach_needs_wait_a: assert property (
        $rose(st_reg.attached) |-> $past(st_reg.det) == UH_DET_WAIT
        && $past(st_reg.cnt) == `UH_CNT_W'(`UH_ATT_CYC - 1))
        else $error("attach set without full settle time");
    irq_gating_a: assert property (
        ##1 attach_irq == $past(st_next.cnn_req & st_next.cnn_ire))
        else $error("interrupt not gated by enable");
    flag_clear_a: assert property (
        wr && wb_req.adr == `UH_OFS_HREQ && !wb_req.dat[`UH_B_CNNREQ]
        && !(st_reg.det == UH_DET_WAIT && present)
        |=> !st_reg.cnn_req ##1 !attach_irq)
        else $error("attach flag not cleared by zero write");
    speed_bit_a: assert property (
        $rose(st_reg.attached) |-> st_reg.speed_fs == $past(st_reg.pin_s2[0]))
        else $error("speed bit does not follow d+");
    ack_in_a: assert property (
        link_ev.rx_data_ok && host_role |=> hs_out.send && hs_out.pid == `UH_PID_ACK)
        else $error("no ack after in data");
    hs_class_a: assert property (
        st_reg.wait_hs && link_ev.hs_valid && !link_ev.tx_data_done
        |=> st_reg.hs_last == $past(link_ev.hs_pid))
        else $error("handshake not captured");
    err_sticky_a: assert property (
        link_ev.crc_err ##1 !(wr && wb_req.adr == `UH_OFS_HERR)
        |-> st_reg.crc_e ##1 st_reg.crc_e)
        else $error("crc error flag lost");
    detach_flag_a: assert property (
        st_reg.det == UH_DET_OFF && !present && st_reg.cnt == `UH_CNT_W'(`UH_ATT_CYC - 1)
        |=> !st_reg.attached && st_reg.dis_req)
        else $error("detach not flagged after settle time");
    never_stall_a: assert property (
        hs_out.send |-> hs_out.pid == `UH_PID_ACK)
        else $error("handshake other than ack sent");
    phase_init_a: assert property (
        st_reg.bfini |-> st_reg.widx == '0 && !st_reg.phase)
        else $error("byte phase not reset by buffer init");
    ack_pulse_a: assert property (
        wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

/* uh_defs.svh */
// constants for the usb host attach logic and endpoint data port
// assumes a 40 mhz clock and a 32-bit classic wishbone register bus
`ifndef UH_DEFS_SVH
`define UH_DEFS_SVH

// register byte offsets
`define UH_OFS_ENABLE 8'h00
`define UH_OFS_HCTRL 8'h04
`define UH_OFS_HOST_LINK_STATE_REG 8'h08
`define UH_OFS_HREQ 8'h0c
`define UH_OFS_FUNC 8'h10
`define UH_OFS_EPDATA 8'h14
`define UH_OFS_HERR 8'h18

// field positions
`define UH_B_USB_BLOCK_ENABLE 0
`define UH_B_HOST 0
`define UH_B_ATTACH_IRQ_ENABLE 1
`define UH_B_ATTACH 0
`define UH_B_SPEED 1
`define UH_B_SPEED_CLOCK_CHOICE 2
`define UH_B_HUBOK 3
`define UH_B_CNNREQ 0
`define UH_B_DISREQ 1
`define UH_B_FRST 0
`define UH_B_BFINI 1
`define UH_B_CRC 0
`define UH_B_TOG 1
`define UH_B_TMO 2
`define UH_F_HS_LO 4
`define UH_F_HS_HI 7

// byte lane selects on the data port
`define UH_SEL_HALF 4'b0011
`define UH_SEL_LOW 4'b0001
`define UH_SEL_HIGH 4'b0010

// handshake codes
`define UH_PID_ACK 4'h2
`define UH_PID_NONE 4'h0

// attach settle time and its cycle count at 40 mhz (least time, rounded up)
`define UH_ATT_NS 2500
`define UH_CLK_NS 25
`define UH_ATT_CYC ((`UH_ATT_NS + `UH_CLK_NS - 1) / `UH_CLK_NS)

// buffer geometry and settle counter width
`define UH_MAX_PKT 256
`define UH_WORDS (`UH_MAX_PKT / 2)
`define UH_WIDX_W 7
`define UH_CNT_W 8

`endif

/* uh_pkg.sv */
// types shared by the usb host attach and data port logic
// assumes uh_defs.svh sits in the same folder
`include "uh_defs.svh"
`default_nettype none
package uh_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } uh_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } uh_wb_rsp_s;

    // events from the packet engine, same clock
    typedef struct packed {
        logic rx_data_ok;
        logic tx_data_done;
        logic hs_valid;
        logic [3:0] hs_pid;
        logic crc_err;
        logic toggle_err;
        logic timeout;
    } uh_link_ev_s;

    typedef struct packed {
        logic send;
        logic [3:0] pid;
    } uh_hs_s;

    typedef enum logic [1:0] {
        UH_DET_IDLE = 2'b00,
        UH_DET_WAIT = 2'b01,
        UH_DET_ON = 2'b10,
        UH_DET_OFF = 2'b11
    } uh_det_e;

    typedef logic [`UH_WORDS-1:0][15:0] uh_mem_t;

    typedef struct packed {
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        uh_det_e det;
        logic [`UH_CNT_W-1:0] cnt;
        logic usb_en;
        logic host_role;
        logic cnn_ire;
        logic clk_sel;
        logic func_rst;
        logic bfini;
        logic attached;
        logic speed_fs;
        logic cnn_req;
        logic dis_req;
        logic crc_e;
        logic tog_e;
        logic tmo_e;
        logic wait_hs;
        logic [3:0] hs_last;
        logic [`UH_WIDX_W-1:0] widx;
        logic phase;
        uh_mem_t mem;
        uh_wb_rsp_s rsp;
        logic irq;
        uh_hs_s hs;
        logic hub_ok;
    } uh_state_s;

endpackage
`default_nettype wire

/* uh_usb_dev_model.sv */
// model of the usb device at the far end of the d+/d- lines
// assumes the bench chooses when the device is plugged in and its speed
`default_nettype none
module uh_usb_dev_model (
    input wire logic clk, // bench clock, times line changes
    input wire logic plug, // device attached
    input wire logic full_spd, // full speed device when high
    output logic dp, // d+ level
    output logic dm // d- level
);
    timeunit 1ns;
    timeprecision 1ps;
    // unplugged: host pull-downs hold both lines low
    // plugged: the device pulls d+ up at full speed, d- at low speed
    always_ff @(posedge clk) begin
        dp <= plug & full_spd;
        dm <= plug & ~full_spd;
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the usb host attach logic and data port
// assumes uh_defs.svh, uh_pkg, uh_host_attach and uh_usb_dev_model
`include "uh_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uh_pkg::*;
    logic clk, srst, plug, fs, dp, dm, irq, en, hr, csel, hub;
    uh_wb_req_s req;
    uh_wb_rsp_s rsp;
    uh_link_ev_s ev;
    uh_hs_s hs;
    int error_cnt, cmp_count, widx_m;
    logic [15:0] mem_m [128];
    logic [15:0] rnd;
    logic [31:0] rd;

    uh_host_attach dut (.clk(clk), .srst(srst), .wb_req(req), .wb_rsp(rsp),
        .dp_in(dp), .dm_in(dm), .link_ev(ev), .hs_out(hs), .attach_irq(irq),
        .usb_enable(en), .host_role(hr), .speed_clock_choice(csel), .hub_ok(hub));
    uh_usb_dev_model dev (.clk(clk), .plug(plug), .full_spd(fs), .dp(dp), .dm(dm));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one classic cycle; the master waits for ack without assuming latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, a, s, d};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 40);
        if (n >= 40) chk("ack", 1, 0);
        rd = rsp.dat;
        req <= '0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 4'hf, 32'h0);
        chk(nm, e, rd);
    endtask

    // data port write, mirrored into the reference buffer
    task automatic pw(input logic [3:0] s, input logic [15:0] d);
        wb(1'b1, `UH_OFS_EPDATA, s, {16'h0, d});
        if (s == `UH_SEL_LOW) mem_m[widx_m][7:0] = d[7:0];
        else if (s == `UH_SEL_HIGH) mem_m[widx_m][15:8] = d[15:8];
        else mem_m[widx_m] = d;
        if (s != `UH_SEL_LOW) widx_m = (widx_m + 1) % 128;
    endtask

    // data port read; only the lanes asked for are compared
    task automatic pr(input logic [3:0] s);
        logic [15:0] m;
        m = {{8{s[1]}}, {8{s[0]}}};
        wb(1'b0, `UH_OFS_EPDATA, s, 32'h0);
        chk("port", {16'h0, mem_m[widx_m] & m}, {16'h0, rd[15:0] & m});
        if (s != `UH_SEL_LOW) widx_m = (widx_m + 1) % 128;
    endtask

    task automatic binit;
        wb(1'b1, `UH_OFS_FUNC, 4'hf, 32'h2);
        wb(1'b1, `UH_OFS_FUNC, 4'hf, 32'h0);
        widx_m = 0;
    endtask

    task automatic evp(input uh_link_ev_s e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= '0;
        #1;
    endtask

    task automatic lines(input logic p, input logic f, input int n);
        @(posedge clk);
        plug <= p;
        fs <= f;
        repeat (n) @(posedge clk);
    endtask

    // watchdog: the whole run needs well under 6000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        srst = 1'b1;
        req = '0;
        ev = '0;
        plug = 1'b0;
        fs = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        widx_m = 0;
        rnd = 16'h0055;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // register reset values; 0x1c is unmapped
        for (int i = 0; i < 8; i++) begin
            if (i != 5) rchk("reset", 8'(i * 4), (i == 4) ? 32'h2 : 32'h0);
        end
        wb(1'b1, 8'h1c, 4'hf, 32'hffffffff);
        rchk("unmapped", 8'h1c, 32'h0);
        wb(1'b1, `UH_OFS_ENABLE, 4'hf, 32'h1);
        chb("usb_enable", 1'b1, en);
        wb(1'b1, `UH_OFS_HCTRL, 4'hf, 32'h3);
        chb("host_role", 1'b1, hr);
        // a short presence is a glitch, not an attach
        lines(1'b1, 1'b1, 50);
        lines(1'b0, 1'b1, 120);
        rchk("glitch", `UH_OFS_HREQ, 32'h0);
        lines(1'b1, 1'b1, 88);
        rchk("early", `UH_OFS_HOST_LINK_STATE_REG, 32'h0);
        repeat (15) @(posedge clk);
        rchk("fs attach", `UH_OFS_HOST_LINK_STATE_REG, 32'hb);
        rchk("cnn flag", `UH_OFS_HREQ, 32'h1);
        chb("irq", 1'b1, irq);
        chb("hub_ok", 1'b1, hub);
        wb(1'b1, `UH_OFS_HREQ, 4'hf, 32'h3);
        chb("irq", 1'b1, irq);
        wb(1'b1, `UH_OFS_HREQ, 4'hf, 32'h0);
        rchk("cnn clr", `UH_OFS_HREQ, 32'h0);
        chb("irq", 1'b0, irq);
        // clock choice is only changed while function reset is held
        wb(1'b1, `UH_OFS_FUNC, 4'hf, 32'h1);
        rchk("frst init", `UH_OFS_FUNC, 32'h3);
        wb(1'b1, `UH_OFS_HOST_LINK_STATE_REG, 4'hf, 32'h4);
        chb("clk choice", 1'b1, csel);
        wb(1'b1, `UH_OFS_FUNC, 4'hf, 32'h0);
        // speed bit keeps the last attach value once the device is gone
        lines(1'b0, 1'b0, 120);
        rchk("detach", `UH_OFS_HOST_LINK_STATE_REG, 32'h6);
        rchk("dis flag", `UH_OFS_HREQ, 32'h2);
        // polling a low speed attach with host role and irq enable off
        wb(1'b1, `UH_OFS_HCTRL, 4'hf, 32'h0);
        wb(1'b1, `UH_OFS_HREQ, 4'hf, 32'h0);
        lines(1'b1, 1'b0, 1);
        rd = '0;
        for (int i = 0; i < 300 && rd[0] !== 1'b1; i++) wb(1'b0, `UH_OFS_HREQ, 4'hf, 0);
        chb("poll", 1'b1, rd[0]);
        rchk("ls attach", `UH_OFS_HOST_LINK_STATE_REG, 32'h5);
        chb("irq gated", 1'b0, irq);
        // handshakes and error flags
        evp(10'h200);
        chk("hs refused", 32'h0, {27'h0, hs});
        wb(1'b1, `UH_OFS_HCTRL, 4'hf, 32'h1);
        evp(10'h200);
        chk("hs ack", 32'h12, {27'h0, hs});
        evp(10'h100);
        evp(10'h0d0);
        rchk("hs pid", `UH_OFS_HERR, 32'ha0);
        evp(10'h004);
        evp(10'h002);
        evp(10'h001);
        rchk("errors", `UH_OFS_HERR, 32'ha7);
        evp(10'h0f8);
        wb(1'b1, `UH_OFS_HERR, 4'hf, 32'h0);
        rchk("err clr", `UH_OFS_HERR, 32'ha0);
        // fill past 256 bytes so the index wraps, then read all back
        wb(1'b1, `UH_OFS_FUNC, 4'hf, 32'h0);
        for (int i = 0; i < 129; i++) begin
            rnd = lfsr(rnd);
            pw(`UH_SEL_HALF, rnd);
        end
        binit();
        for (int i = 0; i < 128; i++) pr(`UH_SEL_HALF);
        // byte pairs mixed with half words; a stray low byte before init
        pw(`UH_SEL_LOW, 16'h00a5);
        binit();
        pw(`UH_SEL_LOW, 16'h003c);
        pw(`UH_SEL_HIGH, 16'hc300);
        pw(`UH_SEL_HALF, lfsr(rnd));
        pw(`UH_SEL_LOW, 16'h0011);
        pw(`UH_SEL_HIGH, 16'h2200);
        binit();
        pr(`UH_SEL_LOW);
        pr(`UH_SEL_HIGH);
        wb(1'b1, `UH_OFS_EPDATA, 4'h4, 32'h5555);
        wb(1'b0, `UH_OFS_EPDATA, 4'h4, 32'h0);
        chk("bad sel", 32'h0, rd);
        pr(`UH_SEL_HALF);
        pr(`UH_SEL_HALF);
        complete_run();
    end
endmodule
`default_nettype wire
